// *** rtl/cfg_lock_pkg.sv ***
// Package: register map, field positions, reset values and bus carrier for the lock/reset bank
package cfg_lock_pkg;

   // ************************************************************
   // Register byte offsets
   // ************************************************************
   localparam logic [15:0] SYSTEM_STATUS_OFS = 16'h2000;
   localparam logic [15:0] SOFT_RESET_CONTROL_OFS = 16'h2004;
   localparam logic [15:0] SYSTEM_CONFIG_ONE_OFS = 16'h2008;
   localparam logic [15:0] LOCK_CONTROL_OFS = 16'h2010;
   localparam logic [15:0] NET_CFG_BASE_OFS = 16'h2100;
   localparam logic [15:0] TRANSCEIVER_CTRL_ZERO_OFS = 16'h2200;
   localparam logic [15:0] TRANSCEIVER_CTRL_ONE_OFS = 16'h2204;

   // Network configuration words, index i sits at NET_CFG_BASE_OFS + 4*i
   localparam int NET_CFG_COUNT = 8;
   localparam int SOURCE_MAC_ADDR_IDX = 0;
   localparam int IPV4_GATEWAY_ADDR_IDX = 1;
   localparam int IPV4_NETMASK_IDX = 2;
   localparam int IPV4_SOURCE_ADDR_IDX = 3;
   localparam int LINK_LOCAL_ADDR_IDX = 4;
   localparam int GLOBAL_UNICAST_ADDR_IDX = 5;
   localparam int IPV6_PREFIX_IDX = 6;
   localparam int IPV6_GATEWAY_ADDR_IDX = 7;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int CHIP_LOCK_FLAG_BIT = 7;
   localparam int NET_LOCK_FLAG_BIT = 6;
   localparam int PHY_LOCK_FLAG_BIT = 5;
   localparam int PARALLEL_BUS_FLAG_BIT = 1;
   localparam int SERIAL_BUS_FLAG_BIT = 0;
   localparam int SOFT_RESET_BIT = 7;

   // Strap patterns on mode pins [3:1]; pin 0 is a don't-care
   localparam logic [2:0] PARALLEL_BUS_MODE = 3'h2;
   localparam logic [2:0] SERIAL_BUS_MODE = 3'h0;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] SOFT_RESET_CONTROL_RST = 8'h80;
   localparam logic [7:0] SYSTEM_CONFIG_ONE_RST = 8'h80;
   localparam logic [7:0] LOCK_CONTROL_RST = 8'h00;
   localparam logic [31:0] NET_CFG_RST = 32'h0000_0000;
   localparam logic [31:0] TRANSCEIVER_CTRL_RST = 32'h0000_0000;
   localparam logic [3:0] MODE_PINS_RST = 4'hF;

   // ************************************************************
   // Wishbone request carrier
   // ************************************************************
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [15:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_t;

endpackage : cfg_lock_pkg

// *** rtl/config_lock_and_soft_reset.sv ***
// Module: configuration lock flags, strap decode and soft reset behind a Wishbone slave
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/100ps

// Overview of operation
// - Status bit 7 shows chip lock; while set, config registers zero and one refuse writes.
// - Soft reset control accepts a write only while chip lock reads zero.
// - Status bit 6 shows network lock; while set, network configuration writes other than the IPv6 gateway are refused.
// - Network lock covers MAC, IPv4 gateway, netmask, IPv4 source, link-local, unicast, prefix.
// - IPv6 gateway address stays writable regardless of network lock.
// - Status bit 5 shows transceiver lock; while set, transceiver control writes are refused.
// - Status bit 1 reads one when mode pins show 010X, otherwise zero.
// - Status bit 0 reads one when mode pins show 000X, otherwise zero.
// - Writing zero to soft reset bit 7 returns every register to default.
// - Writing one to the soft reset bit keeps normal operation, no reset.
module config_lock_and_soft_reset
   import cfg_lock_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire wb_req_t wb_req,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [3:0] mode_pins,
   output logic [7:0] system_config_one,
   output logic [31:0] transceiver_ctrl_zero,
   output logic [31:0] transceiver_ctrl_one,
   output logic soft_reset_pulse
);

   // ************************************************************
   // Decode helpers
   // ************************************************************
   function automatic logic reg_hit(input logic [15:0] adr, input logic [15:0] ofs);
      reg_hit = (adr[15:2] == ofs[15:2]);
   endfunction : reg_hit

   function automatic logic [31:0] byte_merge(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0] sel);
      logic [31:0] merged;
      merged = old_val;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            merged[8*b +: 8] = new_val[8*b +: 8];
         end
      end
      byte_merge = merged;
   endfunction : byte_merge

   // ************************************************************
   // Bus handshake
   // ************************************************************
   logic bus_req;
   logic wr_fire;
   logic rd_fire;
   logic lane0_wr;
   logic soft_rst;
   logic [7:0] lock_control;
   logic chip_locked;
   logic net_locked;
   logic phy_locked;

   // Ack gates the request, so a strobe held through ack is not taken twice
   assign bus_req = wb_req.cyc & wb_req.stb & ~wb_ack_o;
   assign wr_fire = bus_req & wb_req.we;
   assign rd_fire = bus_req & ~wb_req.we;
   assign lane0_wr = wr_fire & wb_req.sel[0];
   assign chip_locked = lock_control[CHIP_LOCK_FLAG_BIT];
   assign net_locked = lock_control[NET_LOCK_FLAG_BIT];
   assign phy_locked = lock_control[PHY_LOCK_FLAG_BIT];

   // One wait state: ack rises the edge after the request, drops the edge after
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wb_ack_o <= 1'b0;
      end
      else
      begin
         wb_ack_o <= bus_req;
      end
   end

   // ************************************************************
   // Mode strap synchroniser
   // ************************************************************
   logic [3:0] mode_meta;
   logic [3:0] mode_s2;
   logic [3:0] mode_s3;
   logic [3:0] mode_stable;
   // Three stages tame metastability; the fourth keeps the last agreed value

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         mode_meta <= MODE_PINS_RST;
         mode_s2 <= MODE_PINS_RST;
         mode_s3 <= MODE_PINS_RST;
         mode_stable <= MODE_PINS_RST;
      end
      else
      begin
         mode_meta <= mode_pins;
         mode_s2 <= mode_meta;
         mode_s3 <= mode_s2;
         // A change counts only once two stages agree
         if (mode_s2 == mode_s3)
         begin
            mode_stable <= mode_s3;
         end
      end
   end

   logic parallel_bus_flag;
   logic serial_bus_flag;

   // Pin zero is a don't-care in both patterns
   assign parallel_bus_flag = (mode_stable[3:1] == PARALLEL_BUS_MODE);
   assign serial_bus_flag = (mode_stable[3:1] == SERIAL_BUS_MODE);

   // ************************************************************
   // Soft reset control
   // ************************************************************
   logic [7:0] soft_reset_control;
   logic cfg0_wr;

   assign cfg0_wr = lane0_wr & reg_hit(wb_req.adr, SOFT_RESET_CONTROL_OFS) & ~chip_locked;

   // Bit drops to zero for one cycle, then the reset restores the default
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         soft_reset_control <= SOFT_RESET_CONTROL_RST;
      end
      else if (soft_rst)
      begin
         soft_reset_control <= SOFT_RESET_CONTROL_RST;
      end
      else if (cfg0_wr)
      begin
         soft_reset_control <= {wb_req.dat[SOFT_RESET_BIT], 7'h00};
      end
   end

   // Reset lasts one cycle; a write landing in that cycle is lost
   assign soft_rst = ~soft_reset_control[SOFT_RESET_BIT];

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         soft_reset_pulse <= 1'b0;
      end
      else
      begin
         soft_reset_pulse <= cfg0_wr & ~wb_req.dat[SOFT_RESET_BIT];
      end
   end

   // ************************************************************
   // Lock flags
   // ************************************************************
   // Stand-in for the key registers: software writes the three flags directly
   // Soft reset clears the locks too, so software must lock again
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         lock_control <= LOCK_CONTROL_RST;
      end
      else if (soft_rst)
      begin
         lock_control <= LOCK_CONTROL_RST;
      end
      else if (lane0_wr & reg_hit(wb_req.adr, LOCK_CONTROL_OFS))
      begin
         lock_control <= {wb_req.dat[7:5], 5'h00};
      end
   end

   // ************************************************************
   // System config one
   // ************************************************************
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         system_config_one <= SYSTEM_CONFIG_ONE_RST;
      end
      else if (soft_rst)
      begin
         system_config_one <= SYSTEM_CONFIG_ONE_RST;
      end
      else if (lane0_wr & reg_hit(wb_req.adr, SYSTEM_CONFIG_ONE_OFS) & ~chip_locked)
      begin
         system_config_one <= wb_req.dat[7:0];
      end
   end

   // ************************************************************
   // Network configuration words
   // ************************************************************
   logic [31:0] net_cfg [NET_CFG_COUNT];

   // Partial writes merge by byte lane
   generate
      for (genvar i = 0; i < NET_CFG_COUNT; i++)
      begin : g_net
         localparam logic [15:0] WORD_OFS = NET_CFG_BASE_OFS + 16'(4 * i);
         // IPv6 gateway word is exempt from the network lock
         localparam logic LOCKABLE = (i != IPV6_GATEWAY_ADDR_IDX);
         logic word_wr;

         assign word_wr = wr_fire & reg_hit(wb_req.adr, WORD_OFS)
                          & ~(LOCKABLE & net_locked);

         always_ff @(posedge clk or negedge nrst)
         begin
            if (!nrst)
            begin
               net_cfg[i] <= NET_CFG_RST;
            end
            else if (soft_rst)
            begin
               net_cfg[i] <= NET_CFG_RST;
            end
            else if (word_wr)
            begin
               net_cfg[i] <= byte_merge(net_cfg[i], wb_req.dat, wb_req.sel);
            end
         end
      end
   endgenerate

   // ************************************************************
   // Transceiver control words
   // ************************************************************
   // Both words share the one transceiver lock
   logic phy0_wr;
   logic phy1_wr;

   assign phy0_wr = wr_fire & reg_hit(wb_req.adr, TRANSCEIVER_CTRL_ZERO_OFS) & ~phy_locked;
   assign phy1_wr = wr_fire & reg_hit(wb_req.adr, TRANSCEIVER_CTRL_ONE_OFS) & ~phy_locked;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         transceiver_ctrl_zero <= TRANSCEIVER_CTRL_RST;
         transceiver_ctrl_one <= TRANSCEIVER_CTRL_RST;
      end
      else if (soft_rst)
      begin
         transceiver_ctrl_zero <= TRANSCEIVER_CTRL_RST;
         transceiver_ctrl_one <= TRANSCEIVER_CTRL_RST;
      end
      else
      begin
         if (phy0_wr)
         begin
            transceiver_ctrl_zero <= byte_merge(transceiver_ctrl_zero, wb_req.dat, wb_req.sel);
         end
         if (phy1_wr)
         begin
            transceiver_ctrl_one <= byte_merge(transceiver_ctrl_one, wb_req.dat, wb_req.sel);
         end
      end
   end

   // ************************************************************
   // Read path
   // ************************************************************
   logic [7:0] system_status;
   logic [31:0] next_rd_data;

   always_comb
   begin
      system_status = 8'h00;
      system_status[CHIP_LOCK_FLAG_BIT] = chip_locked;
      system_status[NET_LOCK_FLAG_BIT] = net_locked;
      system_status[PHY_LOCK_FLAG_BIT] = phy_locked;
      system_status[PARALLEL_BUS_FLAG_BIT] = parallel_bus_flag;
      system_status[SERIAL_BUS_FLAG_BIT] = serial_bus_flag;
   end

   // Write-only and unmapped words read as zero
   always_comb
   begin
      next_rd_data = 32'h0000_0000;
      if (reg_hit(wb_req.adr, SYSTEM_STATUS_OFS))
      begin
         next_rd_data = {24'h000000, system_status};
      end
      else if (reg_hit(wb_req.adr, SYSTEM_CONFIG_ONE_OFS))
      begin
         next_rd_data = {24'h000000, system_config_one};
      end
      else if (reg_hit(wb_req.adr, LOCK_CONTROL_OFS))
      begin
         next_rd_data = {24'h000000, lock_control};
      end
      else if (reg_hit(wb_req.adr, TRANSCEIVER_CTRL_ZERO_OFS))
      begin
         next_rd_data = transceiver_ctrl_zero;
      end
      else if (reg_hit(wb_req.adr, TRANSCEIVER_CTRL_ONE_OFS))
      begin
         next_rd_data = transceiver_ctrl_one;
      end
      else
      begin
         for (int i = 0; i < NET_CFG_COUNT; i++)
         begin
            if (reg_hit(wb_req.adr, NET_CFG_BASE_OFS + 16'(4 * i)))
            begin
               next_rd_data = net_cfg[i];
            end
         end
      end
   end

   // Registered so the data stands in the ack cycle; holds until the next read
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wb_dat_o <= 32'h0000_0000;
      end
      else if (rd_fire)
      begin
         wb_dat_o <= next_rd_data;
      end
   end

endmodule : config_lock_and_soft_reset

// *** verif/cfg_lock_properties.sv ***
// Checker: bus handshake, soft reset and status properties of the lock bank
`timescale 1ns/100ps
module cfg_lock_properties
   import cfg_lock_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire wb_req_t wb_req,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [3:0] mode_pins,
   input wire logic [7:0] system_config_one,
   input wire logic [31:0] transceiver_ctrl_zero,
   input wire logic [31:0] transceiver_ctrl_one,
   input wire logic soft_reset_pulse
);
   // ****************************************
   // Properties
   // ****************************************
   logic take;
   logic [3:0] last_pins;
   logic [3:0] calm;
   assign take = wb_req.cyc && wb_req.stb && !wb_ack_o;
   // Straps need quiet edges to cross the synchroniser
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         last_pins <= 4'hF;
         calm <= 4'h0;
      end
      else
      begin
         last_pins <= mode_pins;
         calm <= (mode_pins != last_pins || soft_reset_pulse) ? 4'h0 : calm + {3'h0, calm != 4'hF};
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence status_read;
      take && !wb_req.we && wb_req.adr == SYSTEM_STATUS_OFS;
   endsequence
   sequence reset_write;
      take && wb_req.we && wb_req.sel[0] && wb_req.adr == SOFT_RESET_CONTROL_OFS
         && !wb_req.dat[SOFT_RESET_BIT];
   endsequence
   a_ack_follows_req: assert property (take |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_pulse_has_cause: assert property (soft_reset_pulse |-> $past(take && wb_req.we
      && wb_req.adr == SOFT_RESET_CONTROL_OFS && !wb_req.dat[SOFT_RESET_BIT]))
      else $error("soft reset pulse without reset write");
   a_pulse_single: assert property (reset_write ##1 soft_reset_pulse |=> !soft_reset_pulse)
      else $error("soft reset pulse too long");
   a_reset_defaults: assert property (soft_reset_pulse |=> system_config_one == 8'h80
      && transceiver_ctrl_zero == 32'h0 && transceiver_ctrl_one == 32'h0)
      else $error("registers not at defaults after soft reset");
   a_status_mode: assert property (calm >= 4'h4 ##0 status_read |=> wb_dat_o[1:0] ==
      {mode_pins[3:1] == PARALLEL_BUS_MODE, mode_pins[3:1] == SERIAL_BUS_MODE})
      else $error("mode flags wrong");
   a_status_reserved: assert property (status_read |=> wb_dat_o[31:8] == 24'h0
      && wb_dat_o[4:2] == 3'h0)
      else $error("reserved status bits set");
   a_cfg_only_write: assert property (!$stable(system_config_one)
      |-> $past(soft_reset_pulse)
      || $past(take && wb_req.we && wb_req.adr == SYSTEM_CONFIG_ONE_OFS))
      else $error("config one changed without write");
   a_phy_only_write: assert property (!$stable(transceiver_ctrl_zero)
      |-> $past(soft_reset_pulse)
      || $past(take && wb_req.we && wb_req.adr == TRANSCEIVER_CTRL_ZERO_OFS))
      else $error("transceiver word changed without write");
endmodule : cfg_lock_properties

bind config_lock_and_soft_reset cfg_lock_properties cfg_lock_properties_inst (.clk(clk),
   .nrst(nrst), .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .mode_pins(mode_pins), .system_config_one(system_config_one),
   .transceiver_ctrl_zero(transceiver_ctrl_zero), .transceiver_ctrl_one(transceiver_ctrl_one),
   .soft_reset_pulse(soft_reset_pulse));

// *** verif/test_config_lock_and_soft_reset.sv ***
// Testbench: register access, locks, strap decode and soft reset
`timescale 1ns/100ps
module test_config_lock_and_soft_reset
   import cfg_lock_pkg::*;
();
   // ****************************************
   // Stimulus and checking
   // ****************************************
   logic clk = 1'b0;
   logic nrst = 1'b0;
   wb_req_t wb_req = '0;
   logic [3:0] mode_pins = 4'hF;
   logic [3:0] lanes = 4'hF;
   logic [31:0] wb_dat_o, transceiver_ctrl_zero, transceiver_ctrl_one, c, r;
   logic wb_ack_o, soft_reset_pulse;
   logic [7:0] system_config_one;
   logic [7:0] locks = 8'h00;
   logic [31:0] exp_q[$];
   logic [31:0] net_exp[8] = '{default: 32'h0};
   int miscompares = 0, samples_checked = 0, pulses = 0, cycles = 0, seed = 81478;
   always #50 clk = ~clk;
   config_lock_and_soft_reset config_lock_and_soft_reset_inst (.clk(clk), .nrst(nrst),
      .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mode_pins(mode_pins),
      .system_config_one(system_config_one), .transceiver_ctrl_zero(transceiver_ctrl_zero),
      .transceiver_ctrl_one(transceiver_ctrl_one), .soft_reset_pulse(soft_reset_pulse));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic final_report;
      $display("Checked %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : final_report
   // Request held until ack is sampled, then idle for a cycle
   task automatic bus(input logic we, input logic [15:0] adr, input logic [31:0] dat);
      wb_req <= '{1'b1, 1'b1, we, adr, lanes, dat};
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      wb_req <= '0;
      @(posedge clk);
   endtask : bus
   task automatic rd(input logic [15:0] adr, input logic [31:0] exp);
      exp_q.push_back(exp);
      bus(1'b0, adr, 32'h0);
   endtask : rd
   function automatic logic [31:0] status(input logic [7:0] lk, input logic [3:0] p);
      return {24'h0, lk[7:5], 3'h0, p[3:1] == 3'h2, p[3:1] == 3'h0};
   endfunction : status
   // Read data is compared at the edge that samples ack
   always @(posedge clk)
   begin
      if (wb_ack_o === 1'b1 && wb_req.we === 1'b0)
         check(wb_dat_o, exp_q.pop_front());
      pulses += soft_reset_pulse;
      cycles++;
      if (cycles > 5000)
      begin
         miscompares++;
         final_report();
      end
   end
   initial
   begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      check({24'h0, system_config_one}, 32'h80);
      for (int p = 0; p < 16; p++)
      begin
         mode_pins <= p[3:0];
         repeat (6) @(posedge clk);
         rd(SYSTEM_STATUS_OFS, status(8'h00, p[3:0]));
      end
      c = $random(seed);
      bus(1'b1, SYSTEM_CONFIG_ONE_OFS, c);
      bus(1'b1, TRANSCEIVER_CTRL_ZERO_OFS, ~c);
      bus(1'b1, TRANSCEIVER_CTRL_ONE_OFS, c);
      for (int pass = 0; pass < 2; pass++)
      begin
         for (int i = 0; i < NET_CFG_COUNT; i++)
         begin
            r = $random(seed);
            bus(1'b1, NET_CFG_BASE_OFS + 16'(4 * i), r);
            if (pass == 0 || i == IPV6_GATEWAY_ADDR_IDX)
               net_exp[i] = r;
            rd(NET_CFG_BASE_OFS + 16'(4 * i), net_exp[i]);
         end
         locks = 8'hE0;
         bus(1'b1, LOCK_CONTROL_OFS, 32'(locks));
      end
      rd(SYSTEM_STATUS_OFS, status(locks, mode_pins));
      bus(1'b1, SYSTEM_CONFIG_ONE_OFS, ~c);
      bus(1'b1, TRANSCEIVER_CTRL_ZERO_OFS, c);
      bus(1'b1, TRANSCEIVER_CTRL_ONE_OFS, ~c);
      bus(1'b1, SOFT_RESET_CONTROL_OFS, 32'h0);
      check({24'h0, system_config_one}, {24'h0, c[7:0]});
      check(transceiver_ctrl_zero, ~c);
      check(transceiver_ctrl_one, c);
      check(32'(pulses), 32'h0);
      bus(1'b1, LOCK_CONTROL_OFS, 32'h60);
      lanes = 4'h5;
      r = $random(seed);
      bus(1'b1, NET_CFG_BASE_OFS + 16'(4 * IPV6_GATEWAY_ADDR_IDX), r);
      lanes = 4'hF;
      net_exp[IPV6_GATEWAY_ADDR_IDX] = (net_exp[IPV6_GATEWAY_ADDR_IDX] & 32'hFF00_FF00)
         | (r & 32'h00FF_00FF);
      rd(NET_CFG_BASE_OFS + 16'(4 * IPV6_GATEWAY_ADDR_IDX), net_exp[IPV6_GATEWAY_ADDR_IDX]);
      bus(1'b1, SOFT_RESET_CONTROL_OFS, 32'h80);
      check(32'(pulses), 32'h0);
      bus(1'b1, SOFT_RESET_CONTROL_OFS, 32'h0);
      check(32'(pulses), 32'h1);
      check(transceiver_ctrl_zero, 32'h0);
      rd(SYSTEM_STATUS_OFS, status(8'h00, mode_pins));
      rd(NET_CFG_BASE_OFS, 32'h0);
      rd(SOFT_RESET_CONTROL_OFS, 32'h0);
      rd(16'h3000, 32'h0);
      bus(1'b1, SYSTEM_CONFIG_ONE_OFS, ~c);
      check({24'h0, system_config_one}, {24'h0, ~c[7:0]});
      final_report();
   end
endmodule : test_config_lock_and_soft_reset
